// ==== hdl/lbp_top.sv ====
// Purpose: device side command decode, burst engines and bank state
// Assumes: link inputs are timed to mem_clk_i; one ca pair per edge
// Notes: row address is not modelled; data array is bank and column only
`timescale 1ns/1ns
module lbp_top (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] cfg_bl_i,
    input wire logic [3:0] cfg_rl_i,
    input wire logic [3:0] cfg_wl_i,
    output logic [lbp_pkg::NBANK-1:0] bank_open_o,
    output logic [lbp_pkg::NBANK-1:0] bank_ready_o,
    input wire logic mem_clk_i,
    input wire logic cs_n_i,
    input wire logic [lbp_pkg::CA_W-1:0] ca_rise_i,
    input wire logic [lbp_pkg::CA_W-1:0] ca_fall_i,
    input wire logic [lbp_pkg::DATA_W-1:0] wdata_i,
    input wire logic [lbp_pkg::MASK_W-1:0] byte_write_mask_i,
    output logic [lbp_pkg::DATA_W-1:0] rdata_o,
    output logic rdata_valid_o
);
    import lbp_pkg::*;

    logic rst_meta_q;
    logic link_rst_q;
    logic [9:0] cfg_raw;
    lbp_cfg_s cfg;
    logic [2*NBANK-1:0] st_sys;
    logic col_cmd;
    logic rd_cmd;
    logic wr_cmd;
    logic bst_cmd;
    logic pre_cmd;
    logic act_cmd;
    logic [1:0] bank;
    logic last_wr_q;
    lbp_cmd_s cur;
    lbp_cmd_s [LINE_DEPTH-1:0] line_q;
    lbp_cmd_s [LINE_DEPTH:0] pipe;
    lbp_cmd_s wtap;
    lbp_cmd_s rtap;
    logic [3:0] half;
    logic [3:0] wr_left_q;
    logic [3:0] rd_left_q;
    logic [MEM_AW-1:0] wr_addr_q;
    logic [MEM_AW-1:0] rd_addr_q;
    logic wr_we;
    logic rd_re;
    logic [MASK_W-1:0] mem_be;
    logic rdata_valid_q;
    logic [NBANK-1:0] pre_hit;
    logic [NBANK-1:0] act_hit;
    logic [NBANK-1:0] open_q;
    logic [NBANK-1:0] open_d;
    logic [NBANK-1:0] rdy_q;
    logic [NBANK-1:0] rdy_d;
    logic [3:0] prc_q [NBANK];
    logic [3:0] prc_d [NBANK];
    logic [4:0] ap_q [NBANK];
    logic [4:0] ap_d [NBANK];
    logic [4:0] half5;
    logic [4:0] rtp_end;
    logic [4:0] rd_ap_dly;
    logic [4:0] wr_ap_dly;

    // latency minus offset, clamped into the command line
    function automatic logic [2:0] lat_idx(input logic [3:0] lat,
                                           input logic [3:0] sub);
        logic [3:0] d;
        d = (lat > sub) ? lat - sub : 4'h0;
        lat_idx = (d > 4'h7) ? 3'h7 : d[2:0];
    endfunction

    // beat pairs per burst, one pair per link cycle
    function automatic logic [3:0] half_bl(input logic [1:0] bl);
        case (bl)
            BL_8: half_bl = 4'h4;
            BL_16: half_bl = 4'h8;
            default: half_bl = 4'h2;
        endcase
    endfunction

    // one hot bank select, or all banks when the flag is set
    function automatic logic [NBANK-1:0] bank_sel(input logic all,
                                                  input logic [1:0] b);
        bank_sel = all ? {NBANK{1'b1}} : NBANK'(1) << b;
    endfunction

    // next column within the same bank, wrapping inside the burst page
    function automatic logic [MEM_AW-1:0] next_addr(
        input logic [MEM_AW-1:0] a);
        next_addr = {a[5:4], a[3:0] + 4'h1};
    endfunction

    // reset brought into the link domain through two flops
    always_ff @(posedge mem_clk_i) begin
        rst_meta_q <= rst_i;
        link_rst_q <= rst_meta_q;
    end

    // configuration is quasi static; change it only while idle
    lbp_sync #(.W(10)) u_cfg_sync (
        .clk_i(mem_clk_i),
        .rst_i(link_rst_q),
        .d_i({cfg_bl_i, cfg_rl_i, cfg_wl_i}),
        .q_o(cfg_raw)
    );
    assign cfg = lbp_cfg_s'(cfg_raw);
    assign half = half_bl(cfg.bl);

    // bank status crosses back to the system clock
    lbp_sync #(.W(2 * NBANK)) u_st_sync (
        .clk_i(sys_clk_i),
        .rst_i(rst_i),
        .d_i({open_q, rdy_q}),
        .q_o(st_sys)
    );

    // status outputs straight from flops
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bank_open_o <= '0;
            bank_ready_o <= '0;
        end else begin
            bank_open_o <= st_sys[2*NBANK-1:NBANK];
            bank_ready_o <= st_sys[NBANK-1:0];
        end
    end

    // command decode at the rising edge
    assign col_cmd = !cs_n_i && ca_rise_i[1:0] == OP_COL;
    assign rd_cmd = col_cmd && ca_rise_i[2];
    assign wr_cmd = col_cmd && !ca_rise_i[2];
    assign bst_cmd = !cs_n_i && ca_rise_i[3:0] == OP_BST;
    assign pre_cmd = !cs_n_i && ca_rise_i[3:0] == OP_PRE;
    assign act_cmd = !cs_n_i && ca_rise_i[1:0] == OP_ACT;
    assign bank = ca_rise_i[CA_BA_LO+:2];

    // a stop is aimed at whichever burst kind came last
    always_comb begin
        cur = CMD_IDLE;
        cur.rd = rd_cmd;
        cur.wr = wr_cmd;
        cur.burst_stop_cmd = bst_cmd;
        cur.to_wr = bst_cmd ? last_wr_q : wr_cmd;
        cur.ap = col_cmd && ca_fall_i[CA_AP_BIT];
        cur.bank = bank;
        cur.col = ca_fall_i[CA_COL_LO+:4];
    end

    // remembers the kind of the most recent column command
    always_ff @(posedge mem_clk_i) begin
        if (link_rst_q) begin
            last_wr_q <= 1'b0;
        end else if (col_cmd) begin
            last_wr_q <= wr_cmd;
        end
    end

    // command line: delays each command toward its latency tap
    always_ff @(posedge mem_clk_i) begin
        if (link_rst_q) begin
            line_q <= '{default: CMD_IDLE};
        end else begin
            line_q <= {line_q[LINE_DEPTH-2:0], cur};
        end
    end
    assign pipe = {line_q, cur};
    assign wtap = pipe[lat_idx(cfg.wl, 4'h1)];
    assign rtap = pipe[lat_idx(cfg.rl, 4'h2)];

    // write engine: a new write restarts it, so the earlier burst keeps
    // exactly the pairs taken before the restart
    always_ff @(posedge mem_clk_i) begin
        if (link_rst_q) begin
            wr_left_q <= 4'h0;
            wr_addr_q <= '0;
        end else if (wtap.wr) begin
            wr_left_q <= half;
            wr_addr_q <= {wtap.bank, wtap.col};
        end else if (wtap.burst_stop_cmd && wtap.to_wr) begin
            wr_left_q <= 4'h0;
        end else if (wr_left_q != 4'h0) begin
            wr_left_q <= wr_left_q - 4'h1;
            wr_addr_q <= next_addr(wr_addr_q);
        end
    end
    assign wr_we = wr_left_q != 4'h0;
    assign mem_be = ~byte_write_mask_i;

    // read engine: issue edge is one ahead, the array read adds one
    always_ff @(posedge mem_clk_i) begin
        if (link_rst_q) begin
            rd_left_q <= 4'h0;
            rd_addr_q <= '0;
        end else if (rtap.rd) begin
            rd_left_q <= half;
            rd_addr_q <= {rtap.bank, rtap.col};
        end else if (rtap.burst_stop_cmd && !rtap.to_wr) begin
            rd_left_q <= 4'h0;
        end else if (rd_left_q != 4'h0) begin
            rd_left_q <= rd_left_q - 4'h1;
            rd_addr_q <= next_addr(rd_addr_q);
        end
    end
    assign rd_re = rd_left_q != 4'h0;

    // valid lines up with the registered array output
    always_ff @(posedge mem_clk_i) begin
        if (link_rst_q) begin
            rdata_valid_q <= 1'b0;
        end else begin
            rdata_valid_q <= rd_re;
        end
    end
    assign rdata_valid_o = rdata_valid_q;

    lbp_mem u_mem (
        .clk_i(mem_clk_i),
        .rst_i(link_rst_q),
        .we_i(wr_we),
        .waddr_i(wr_addr_q),
        .wdata_i(wdata_i),
        .be_i(mem_be),
        .re_i(rd_re),
        .raddr_i(rd_addr_q),
        .rdata_o(rdata_o)
    );

    // auto close delays, counted from the command edge
    always_comb begin
        half5 = {1'b0, half};
        rtp_end = half5 - 5'h02 + RTP_CYC;
        rd_ap_dly = (rtp_end > half5) ? rtp_end : half5;
        wr_ap_dly = {1'b0, cfg.wl} + half5 + 5'h01 + WR_CYC;
    end
    assign pre_hit = pre_cmd ? bank_sel(ca_rise_i[CA_AB_BIT], bank) : '0;
    assign act_hit = act_cmd ? bank_sel(1'b0, bank) : '0;

    // per bank open state, precharge timer and auto close countdown
    always_comb begin
        for (int b = 0; b < NBANK; b++) begin
            open_d[b] = open_q[b];
            prc_d[b] = (prc_q[b] != 4'h0) ? prc_q[b] - 4'h1 : 4'h0;
            ap_d[b] = (ap_q[b] != 5'h00) ? ap_q[b] - 5'h01 : 5'h00;
            if (pre_hit[b] || ap_q[b] == 5'h01) begin
                open_d[b] = 1'b0;
                prc_d[b] = RP_CYC;
            end else if (act_hit[b]) begin
                open_d[b] = 1'b1;
            end
            if (cur.ap && bank == 2'(b)) begin
                ap_d[b] = rd_cmd ? rd_ap_dly : wr_ap_dly;
            end
            rdy_d[b] = !open_d[b] && prc_d[b] == 4'h0;
        end
    end

    // bank state registers
    always_ff @(posedge mem_clk_i) begin
        if (link_rst_q) begin
            open_q <= '0;
            rdy_q <= '1;
            prc_q <= '{default: 4'h0};
            ap_q <= '{default: 5'h00};
        end else begin
            open_q <= open_d;
            rdy_q <= rdy_d;
            prc_q <= prc_d;
            ap_q <= ap_d;
        end
    end

    default clocking cb @(posedge mem_clk_i);
    endclocking
    default disable iff (link_rst_q);

    col_decode_a: assert property (
        rd_cmd |=> line_q[0].rd && !line_q[0].wr
    ) else $error("read command not decoded");

    bst_decode_a: assert property (
        (!cs_n_i && ca_rise_i[3:0] == 4'h3) |=> line_q[0].burst_stop_cmd
    ) else $error("burst stop not decoded");

    wr_restart_a: assert property (
        wtap.wr |=> wr_left_q == $past(half) && wr_we
    ) else $error("write burst did not restart");

    wr_stop_a: assert property (
        wtap.burst_stop_cmd && wtap.to_wr |=> !wr_we ##1 !wr_we
    ) else $error("write burst kept taking data after stop");

    rd_stop_a: assert property (
        rtap.burst_stop_cmd && !rtap.to_wr |=> !rd_re ##1 !rdata_valid_o
    ) else $error("read burst kept driving data after stop");

    stop_recent_a: assert property (
        rtap.burst_stop_cmd && rtap.to_wr && rd_left_q > 4'h1
            |=> rd_left_q == $past(rd_left_q) - 4'h1
    ) else $error("stop hit an older read burst");

    byte_mask_a: assert property (
        wr_we && byte_write_mask_i[0] |-> !mem_be[0]
    ) else $error("masked byte was written");

    pre_bank_a: assert property (
        pre_cmd && !ca_rise_i[CA_AB_BIT]
            |=> !open_q[$past(bank)] && prc_q[$past(bank)] == RP_CYC
    ) else $error("single bank precharge missed its bank");

    pre_all_a: assert property (
        pre_cmd && ca_rise_i[CA_AB_BIT] |=> open_q == 4'h0 && rdy_q == 4'h0
    ) else $error("all bank precharge left a bank open");

    act_open_a: assert property (
        act_cmd && ap_q[bank] != 5'h01 |=> open_q[$past(bank)]
    ) else $error("activate did not open bank");

    rd_close_a: assert property (
        rd_cmd && cur.ap |=> ap_q[$past(bank)] == $past(rd_ap_dly)
    ) else $error("read auto close delay wrong");

    ap_close_a: assert property (
        ap_q[0] == 5'h01 |=> !open_q[0]
            ##1 (!open_q[0] || $past(act_hit[0]))
    ) else $error("auto close left bank 0 open");
endmodule

// ==== hdl/lbp_pkg.sv ====
// Purpose: shared constants and types for the lpddr2 burst/precharge core
// Assumes: one command per link clock edge; fall half of ca shown with rise
// Notes: times in ns; cycle counts derived at the link clock period
// Behaviour
// - interrupted write delivers twice the cycles between the two writes
// - burst stop: chip select low, ca3..ca0 = 0,0,1,1
// - stopped burst length is twice the cycles from command to stop
// - burst stop acts only on the most recent read or write
// - read data stops read latency after the burst stop edge
// - write data stops being taken write latency after burst stop
// - one mask per byte; high mask blocks that byte on that beat
// - precharge: chip select low, ca3..ca0 = 1,0,1,1; one or all banks
// - all bank flag closes all; else two bank bits pick one bank
// - bank usable after precharge time, same for single and all
// - auto close low keeps bank open; high closes it automatically
// - read auto close starts at later of half or half-2+rtp cycles
// - column access: ca0 high, ca1 low; ca2 high read, low write
// - write auto close starts recovery cycles after burst completes
package lbp_pkg;
    localparam int LINK_PERIOD_NS = 30;
    localparam int T_RP_NS = 18;
    localparam int T_RTP_NS = 8;
    localparam int T_WR_NS = 15;
    localparam logic [3:0] RP_CYC =
        4'((T_RP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
    localparam logic [4:0] RTP_CYC =
        5'((T_RTP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
    localparam logic [4:0] WR_CYC =
        5'((T_WR_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
    localparam int NBANK = 4;
    localparam int DATA_W = 64;
    localparam int MASK_W = 8;
    localparam int MEM_AW = 6;
    localparam int LINE_DEPTH = 7;
    localparam int CA_W = 10;
    localparam int CA_AB_BIT = 4;
    localparam int CA_BA_LO = 7;
    localparam int CA_AP_BIT = 0;
    localparam int CA_COL_LO = 1;
    localparam logic [1:0] OP_COL = 2'h1;
    localparam logic [1:0] OP_ACT = 2'h2;
    localparam logic [3:0] OP_BST = 4'h3;
    localparam logic [3:0] OP_PRE = 4'hb;
    localparam logic [1:0] BL_8 = 2'h1;
    localparam logic [1:0] BL_16 = 2'h2;
    typedef struct packed {
        logic rd;
        logic wr;
        logic burst_stop_cmd;
        logic to_wr;
        logic ap;
        logic [1:0] bank;
        logic [3:0] col;
    } lbp_cmd_s;
    typedef struct packed {
        logic [1:0] bl;
        logic [3:0] rl;
        logic [3:0] wl;
    } lbp_cfg_s;
    localparam lbp_cmd_s CMD_IDLE = '0;
endpackage

// ==== hdl/lbp_sync.sv ====
// Purpose: two flop level synchroniser
// Assumes: input levels are quasi static across the crossing
// Notes: bits are not coherent with each other while they change
`timescale 1ns/1ns
module lbp_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// ==== hdl/lbp_mem.sv ====
// Purpose: small byte maskable data array with registered read
// Assumes: one write and one read port on the link clock
// Notes: array has no reset; only the read register clears
`timescale 1ns/1ns
module lbp_mem (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [lbp_pkg::MEM_AW-1:0] waddr_i,
    input wire logic [lbp_pkg::DATA_W-1:0] wdata_i,
    input wire logic [lbp_pkg::MASK_W-1:0] be_i,
    input wire logic re_i,
    input wire logic [lbp_pkg::MEM_AW-1:0] raddr_i,
    output logic [lbp_pkg::DATA_W-1:0] rdata_o
);
    import lbp_pkg::*;
    logic [DATA_W-1:0] mem_q [2**MEM_AW];

    // byte lanes written only where enabled
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            for (int i = 0; i < MASK_W; i++) begin
                if (be_i[i]) begin
                    mem_q[waddr_i][i*8+:8] <= wdata_i[i*8+:8];
                end
            end
        end
    end

    // read data held between reads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (re_i) begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule

// ==== tb/lbp_ctrl_model.sv ====
// Purpose: controller side model driving the command and data lines
// Assumes: lines change 1 ns after a link clock rise
// Notes: idle ca and data lines show the inverse of their last value, never a hold; chip select holds high
`timescale 1ns/1ns
module lbp_ctrl_model (
    input wire logic mem_clk_i,
    output logic cs_n_o,
    output logic [9:0] ca_rise_o,
    output logic [9:0] ca_fall_o,
    output logic [63:0] wdata_o,
    output logic [7:0] mask_o,
    input wire logic [63:0] rdata_i,
    input wire logic rdata_valid_i
);
    int cyc = 0;
    int wl = 2;
    int mk_pair = -1;
    logic [7:0] mk_val = 8'h00;
    logic pend = 1'b0;
    logic [9:0] pr = '0;
    logic [9:0] pf = '0;
    logic [63:0] wd[int];
    logic [7:0] wm[int];
    logic [63:0] rq[$];
    initial begin
        cs_n_o = 1'b1;
        ca_rise_o = '0;
        ca_fall_o = '0;
        wdata_o = '0;
        mask_o = '0;
    end
    // edge count and read capture; tasks read cyc before it moves
    always @(posedge mem_clk_i) begin
        cyc <= cyc + 1;
        if (rdata_valid_i === 1'b1) begin
            rq.push_back(rdata_i);
        end
    end
    // ca and data lines toggle when idle so a stale value cannot pass for a good one
    always @(posedge mem_clk_i) begin
        #1;
        cs_n_o = ~pend;
        ca_rise_o = pend ? pr : ~ca_rise_o;
        ca_fall_o = pend ? pf : ~ca_fall_o;
        pend = 1'b0;
        wdata_o = wd.exists(cyc + 1) ? wd[cyc + 1] : ~wdata_o;
        mask_o = wm.exists(cyc + 1) ? wm[cyc + 1] : ~mask_o;
    end
    // one command, sampled at the next edge, whose number returns in c
    task automatic cmd(input logic [9:0] r, input logic [9:0] f,
                       output int c);
        @(posedge mem_clk_i);
        c = cyc + 2;
        pr = r;
        pf = f;
        pend = 1'b1;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mem_clk_i);
    endtask
    // caller may cut a plain write with another write but never cuts an auto close burst
    task automatic wr(input logic [1:0] b, input logic [3:0] col,
                      input logic ap, input logic [63:0] base, input int n);
        int c;
        cmd({1'b0, b, 7'h01}, {5'h00, col, ap}, c);
        for (int i = 0; i < n; i++) begin
            wd[c + wl + i] = base + 64'(i);
            wm[c + wl + i] = (i == mk_pair) ? mk_val : 8'h00;
        end
    endtask
    task automatic rd(input logic [1:0] b, input logic [3:0] col,
                      input logic ap);
        int c;
        cmd({1'b0, b, 7'h05}, {5'h00, col, ap}, c);
    endtask
    task automatic act(input logic [1:0] b);
        int c;
        cmd({1'b0, b, 7'h02}, 10'h000, c);
    endtask
    // issued only on a live burst, an even count after it, once
    task automatic burst_stop_cmd();
        int c;
        cmd(10'h003, 10'h000, c);
    endtask
    // callers leave the read and write recovery gaps before this
    task automatic pre(input logic all, input logic [1:0] b);
        int c;
        cmd({1'b0, b, 2'b00, all, 4'hb}, 10'h000, c);
    endtask
endmodule

// ==== tb/testbench.sv ====
// Purpose: directed checks of burst stop, masking and precharge
// Assumes: burst 16, read latency 3, write latency 2 unless changed
// Notes: reset held long enough for both clocks to see it
`timescale 1ns/1ns
module testbench;
    import lbp_pkg::*;
    localparam logic [63:0] PQ = 64'h1111_1111_2222_0000;
    localparam logic [63:0] PP = 64'h3333_3333_4444_0000;
    localparam logic [63:0] PR = 64'h5555_5555_6666_0000;
    logic sys_clk_i = 1'b0;
    logic mem_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] cfg_bl = BL_16;
    logic [3:0] cfg_rl = 4'h3;
    logic [3:0] cfg_wl = 4'h2;
    logic [NBANK-1:0] bank_open;
    logic [NBANK-1:0] bank_ready;
    logic cs_n;
    logic [CA_W-1:0] ca_r;
    logic [CA_W-1:0] ca_f;
    logic [DATA_W-1:0] wdata;
    logic [MASK_W-1:0] mask;
    logic [DATA_W-1:0] rdata;
    logic rdata_valid;
    logic [63:0] ev;
    int fails = 0;
    int samples_checked = 0;
    initial forever #5 sys_clk_i = ~sys_clk_i;
    // link clock offset so its edges never line up with the system clock
    initial begin
        #7;
        forever #15 mem_clk_i = ~mem_clk_i;
    end
    lbp_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_bl_i(cfg_bl),
        .cfg_rl_i(cfg_rl), .cfg_wl_i(cfg_wl), .bank_open_o(bank_open),
        .bank_ready_o(bank_ready), .mem_clk_i(mem_clk_i), .cs_n_i(cs_n),
        .ca_rise_i(ca_r), .ca_fall_i(ca_f), .wdata_i(wdata),
        .byte_write_mask_i(mask), .rdata_o(rdata),
        .rdata_valid_o(rdata_valid));
    lbp_ctrl_model u_ctrl (.mem_clk_i(mem_clk_i), .cs_n_o(cs_n),
        .ca_rise_o(ca_r), .ca_fall_o(ca_f), .wdata_o(wdata), .mask_o(mask),
        .rdata_i(rdata), .rdata_valid_i(rdata_valid));
    task automatic chk_bank(input string n, input logic [3:0] e,
                            input logic [3:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_data(input string n, input logic [63:0] e,
                            input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // bounded wait for n read pairs, then a few more edges for extras
    task automatic wait_reads(input int n);
        int k;
        k = 0;
        while (u_ctrl.rq.size() < n && k < 40) begin
            @(posedge mem_clk_i);
            k++;
        end
        if (u_ctrl.rq.size() < n) begin
            fails++;
            report_and_stop();
        end else begin
            u_ctrl.idle(4);
        end
    endtask
    // config is only changed while the link is idle; model latency follows
    task automatic set_cfg(input logic [1:0] v, input logic [3:0] r,
                           input logic [3:0] w);
        @(posedge sys_clk_i);
        #1;
        cfg_bl = v;
        cfg_rl = r;
        cfg_wl = w;
        u_ctrl.wl = int'(w);
        u_ctrl.idle(4);
    endtask
    initial begin
        repeat (14) @(posedge sys_clk_i);
        #1;
        chk_bank("open in reset", 4'h0, bank_open);
        chk_data("valid in reset", 64'h0, 64'(rdata_valid));
        rst_i = 1'b0;
        u_ctrl.idle(8);
        chk_bank("ready after reset", 4'hf, bank_ready);
        for (int b = 0; b < 4; b++) u_ctrl.act(2'(b));
        u_ctrl.idle(3);
        chk_bank("open after activate", 4'hf, bank_open);
        chk_bank("ready after activate", 4'h0, bank_ready);
        // prefill both banks, then interrupt, mask and stop
        u_ctrl.wr(2'd0, 4'h0, 1'b0, PQ, 8);
        u_ctrl.idle(8);
        u_ctrl.wr(2'd1, 4'h0, 1'b0, PQ, 8);
        u_ctrl.idle(8);
        u_ctrl.mk_pair = 1;
        u_ctrl.mk_val = 8'hf0;
        u_ctrl.wr(2'd0, 4'h0, 1'b0, PP, 8);
        u_ctrl.mk_pair = -1;
        u_ctrl.idle(1);
        u_ctrl.wr(2'd1, 4'h0, 1'b0, PR, 8);
        u_ctrl.idle(1);
        u_ctrl.burst_stop_cmd();
        u_ctrl.idle(10);
        u_ctrl.rq.delete();
        u_ctrl.rd(2'd0, 4'h0, 1'b0);
        wait_reads(8);
        for (int i = 0; i < 8; i++) begin
            ev = PQ + 64'(i);
            if (i == 0) ev = PP;
            if (i == 1) ev = {PQ[63:32], PP[31:0] + 32'h1};
            chk_data("interrupted bank0", ev, u_ctrl.rq[i]);
        end
        // read cut by a stop four cycles on: four pairs only
        u_ctrl.rq.delete();
        u_ctrl.rd(2'd1, 4'h0, 1'b0);
        u_ctrl.idle(3);
        u_ctrl.burst_stop_cmd();
        wait_reads(4);
        chk_data("stopped read count", 64'h4,
                 64'(u_ctrl.rq.size()));
        for (int i = 0; i < 4; i++) begin
            ev = ((i < 2) ? PR : PQ) + 64'(i);
            chk_data("stopped write bank1", ev, u_ctrl.rq[i]);
        end
        // burst length codes 0, 1 and 2 each give their pair count
        for (int k = 0; k < 3; k++) begin
            set_cfg(2'(k), 4'h3, 4'h2);
            u_ctrl.rq.delete();
            u_ctrl.rd(2'd0, 4'h0, 1'b0);
            wait_reads(2 << k);
            chk_data("burst count", 64'(2 << k),
                     64'(u_ctrl.rq.size()));
        end
        set_cfg(BL_16, 4'h3, 4'h2);
        u_ctrl.idle(8);
        for (int b = 0; b < 4; b++) begin
            u_ctrl.pre(1'b0, 2'(b));
            u_ctrl.idle(3);
            chk_bank("single close", 4'(4'hf << (b + 1)), bank_open);
        end
        chk_bank("ready after close", 4'hf, bank_ready);
        for (int b = 0; b < 4; b++) u_ctrl.act(2'(b));
        u_ctrl.idle(6);
        u_ctrl.pre(1'b1, 2'b10);
        u_ctrl.idle(3);
        chk_bank("all close", 4'h0, bank_open);
        chk_bank("ready after all", 4'hf, bank_ready);
        // auto close off keeps the bank, on closes it
        u_ctrl.act(2'd2);
        u_ctrl.act(2'd3);
        u_ctrl.idle(6);
        u_ctrl.rd(2'd2, 4'h0, 1'b0);
        u_ctrl.idle(12);
        chk_bank("read keeps open", 4'hc, bank_open);
        u_ctrl.rd(2'd2, 4'h0, 1'b1);
        u_ctrl.idle(12);
        chk_bank("read auto close", 4'h8, bank_open);
        u_ctrl.wr(2'd3, 4'h0, 1'b1, PQ, 8);
        u_ctrl.idle(16);
        chk_bank("write auto close", 4'h0, bank_open);
        // read latency 8, write latency 4, low lanes masked, read closes bank 0 itself
        set_cfg(BL_16, 4'h8, 4'h4);
        u_ctrl.act(2'd0);
        u_ctrl.idle(4);
        u_ctrl.mk_pair = 0;
        u_ctrl.mk_val = 8'h0f;
        u_ctrl.wr(2'd0, 4'h0, 1'b0, PR, 8);
        u_ctrl.mk_pair = -1;
        u_ctrl.idle(16);
        u_ctrl.rq.delete();
        u_ctrl.rd(2'd0, 4'h0, 1'b1);
        u_ctrl.idle(8);
        #1;
        chk_data("pairs before latency", 64'h0,
                 64'(u_ctrl.rq.size()));
        u_ctrl.idle(1);
        #1;
        chk_data("pairs at latency", 64'h1,
                 64'(u_ctrl.rq.size()));
        wait_reads(8);
        for (int i = 0; i < 8; i++) begin
            ev = PR + 64'(i);
            if (i == 0) ev = {PR[63:32], PP[31:0]};
            chk_data("long latency bank0", ev, u_ctrl.rq[i]);
        end
        chk_bank("read auto close bank0", 4'h0, bank_open);
        report_and_stop();
    end
endmodule
